// ==== shared/eprom_host_pkg.sv ====
// Purpose: Constants shared by the memory programmer controller.
// Assumes: 100 MHz system clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package eprom_host_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int TIMER_W = 16;
  // Address, data and supply setup before and hold after a pulse
  localparam int SETUP_US = 2;
  localparam int SETUP_CYCLES = (SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Default program pulse width
  localparam int PULSE_US = 100;
  localparam int PULSE_CYCLES = (PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Default worst access delay of the slowest part
  localparam int ACCESS_NS = 250;
  // Output float time after the gate rises
  localparam int FLOAT_NS = 130;
  localparam int FLOAT_CYCLES = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Depth of the data input synchroniser
  localparam int SYNC_STAGES = 2;
  // Command codes
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_PROGRAM_SHARED = 2'h2;
  localparam logic [1:0] OP_IDENTIFY = 2'h3;
endpackage

// ==== rtl/cycle_timer.sv ====
// Purpose: Down counter timing each phase of a pin sequence.
// Assumes: Load value is the phase length minus one.
// Notes: done is high while the count is zero.
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic done
);
  logic [WIDTH-1:0] count;

  // Load wins over the running count
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      count <= '0;
    else if (load)
      count <= load_value;
    else if (count != '0)
      count <= count - 1'b1;
  end

  assign done = (count == '0);
endmodule
`default_nettype wire

// ==== rtl/eprom_host.sv ====
// Purpose: Programmer end driving a byte-wide programmable ROM by its pins.
// Assumes: Supply enables switch external regulators; data_in is asynchronous.
// Notes: One command at a time; response returns after the pins are idle.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Program with supply high, select low, gate high
// - Select low pulse at supply programs byte
// - Programmer verifies every programmed byte
// - Shared bus: lower supply, verify by read
// - Identifier entry: high voltage, both enables low
// - Identifier readout keeps other addresses low
// - Gate only with host released, no contention; standard verify gates with select high
module eprom_host #(
  parameter int PULSE_CYCLES = eprom_host_pkg::PULSE_CYCLES,
  parameter int ACCESS_NS = eprom_host_pkg::ACCESS_NS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [eprom_host_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [eprom_host_pkg::DATA_W-1:0] cmd_data,
  output logic rsp_valid,
  output logic [eprom_host_pkg::DATA_W-1:0] rsp_data,
  output logic rsp_match,
  output logic [eprom_host_pkg::ADDR_W-1:0] dev_addr,
  output logic device_select_n,
  output logic output_gate_n,
  output logic [eprom_host_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic [eprom_host_pkg::DATA_W-1:0] data_in,
  output logic program_supply_en,
  output logic core_supply_high_en,
  output logic id_high_voltage_en
);
  localparam int ACCESS_CYCLES = (ACCESS_NS + eprom_host_pkg::CLK_PERIOD_NS - 1)
    / eprom_host_pkg::CLK_PERIOD_NS + eprom_host_pkg::SYNC_STAGES;
  localparam int TW = eprom_host_pkg::TIMER_W;

  // Refuse phase lengths the timer cannot hold
  if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << TW))
    $error("PULSE_CYCLES out of range");
  if (ACCESS_CYCLES >= (1 << TW))
    $error("ACCESS_NS out of range");

  typedef enum {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_SETTLE, ST_ACCESS, ST_SAMPLE,
    ST_FLOAT} state_t;

  state_t state;
  state_t next_state;
  logic [1:0] op;
  logic [eprom_host_pkg::DATA_W-1:0] wdata;
  logic [eprom_host_pkg::DATA_W-1:0] data_meta;
  logic [eprom_host_pkg::DATA_W-1:0] data_sync;
  logic [eprom_host_pkg::DATA_W-1:0] captured;
  logic tmr_load;
  logic [TW-1:0] tmr_value;
  logic tmr_done;
  logic is_prog;
  logic take;

  assign is_prog = (op == eprom_host_pkg::OP_PROGRAM) || (op == eprom_host_pkg::OP_PROGRAM_SHARED);
  assign take = cmd_valid && cmd_ready;

  cycle_timer #(
    .WIDTH(TW)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(tmr_load),
    .load_value(tmr_value),
    .done(tmr_done)
  );

  // Two-stage synchroniser for the device data pins
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      data_meta <= '0;
      data_sync <= '0;
    end
    else
    begin
      data_meta <= data_in;
      data_sync <= data_meta;
    end
  end

  // Phase sequencing and timer loads
  always_comb
  begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_value = '0;
    case (state)
      ST_IDLE:
        if (take)
        begin
          next_state = ST_SETUP;
          tmr_load = 1'b1;
          tmr_value = TW'(eprom_host_pkg::SETUP_CYCLES - 1);
        end
      ST_SETUP:
        if (tmr_done)
        begin
          tmr_load = 1'b1;
          if (is_prog)
          begin
            next_state = ST_PULSE;
            tmr_value = TW'(PULSE_CYCLES - 1);
          end
          else
          begin
            next_state = ST_ACCESS;
            tmr_value = TW'(ACCESS_CYCLES - 1);
          end
        end
      ST_PULSE:
        if (tmr_done)
        begin
          next_state = ST_HOLD;
          tmr_load = 1'b1;
          tmr_value = TW'(eprom_host_pkg::SETUP_CYCLES - 1);
        end
      ST_HOLD:
        if (tmr_done)
        begin
          next_state = ST_SETTLE;
          tmr_load = 1'b1;
          tmr_value = TW'(eprom_host_pkg::SETUP_CYCLES - 1);
        end
      ST_SETTLE:
        if (tmr_done)
        begin
          next_state = ST_ACCESS;
          tmr_load = 1'b1;
          tmr_value = TW'(ACCESS_CYCLES - 1);
        end
      ST_ACCESS:
        if (tmr_done)
          next_state = ST_SAMPLE;
      ST_SAMPLE:
      begin
        next_state = ST_FLOAT;
        tmr_load = 1'b1;
        tmr_value = TW'(eprom_host_pkg::FLOAT_CYCLES - 1);
      end
      ST_FLOAT:
        if (tmr_done)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Command capture and address pins
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      op <= eprom_host_pkg::OP_READ;
      wdata <= '0;
      dev_addr <= '0;
    end
    else if (take)
    begin
      op <= cmd_op;
      wdata <= cmd_data;
      if (cmd_op == eprom_host_pkg::OP_IDENTIFY)
        dev_addr <= {{(eprom_host_pkg::ADDR_W-1){1'b0}}, cmd_addr[0]};
      else
        dev_addr <= cmd_addr;
    end
  end

  // Enable pins follow the phase being entered
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      device_select_n <= 1'b1;
      output_gate_n <= 1'b1;
    end
    else
    begin
      // Pulse programs; standard verify keeps select high
      device_select_n <= !((next_state == ST_PULSE)
        || ((next_state == ST_ACCESS || next_state == ST_SAMPLE)
        && op != eprom_host_pkg::OP_PROGRAM));
      // Gate only during the read window, never while driving
      output_gate_n <= !(next_state == ST_ACCESS || next_state == ST_SAMPLE);
    end
  end

  // Data drive during setup, pulse and hold
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      data_out <= '0;
      data_oe_n <= 1'b1;
    end
    else
    begin
      data_out <= wdata;
      data_oe_n <= !(is_prog && (next_state == ST_SETUP || next_state == ST_PULSE
        || next_state == ST_HOLD));
      if (take)
        data_out <= cmd_data;
      if (take)
        data_oe_n <= !(cmd_op == eprom_host_pkg::OP_PROGRAM
          || cmd_op == eprom_host_pkg::OP_PROGRAM_SHARED);
    end
  end

  // Supply and identifier voltage switches
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      program_supply_en <= 1'b0;
      core_supply_high_en <= 1'b0;
      id_high_voltage_en <= 1'b0;
    end
    else if (take)
    begin
      program_supply_en <= (cmd_op == eprom_host_pkg::OP_PROGRAM)
        || (cmd_op == eprom_host_pkg::OP_PROGRAM_SHARED);
      core_supply_high_en <= (cmd_op == eprom_host_pkg::OP_PROGRAM)
        || (cmd_op == eprom_host_pkg::OP_PROGRAM_SHARED);
      id_high_voltage_en <= (cmd_op == eprom_host_pkg::OP_IDENTIFY);
    end
    else if (next_state == ST_IDLE)
    begin
      program_supply_en <= 1'b0;
      core_supply_high_en <= 1'b0;
      id_high_voltage_en <= 1'b0;
    end
    else if (next_state == ST_SETTLE && op == eprom_host_pkg::OP_PROGRAM_SHARED)
      program_supply_en <= 1'b0;
  end

  // Handshake and response
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_match <= 1'b0;
      captured <= '0;
    end
    else
    begin
      cmd_ready <= (next_state == ST_IDLE) && !take;
      rsp_valid <= (state == ST_FLOAT) && (next_state == ST_IDLE);
      if (state == ST_SAMPLE)
        captured <= data_sync;
      if ((state == ST_FLOAT) && (next_state == ST_IDLE))
      begin
        rsp_data <= captured;
        rsp_match <= !is_prog || (captured == wdata);
      end
    end
  end

  AST_PROG_GATE_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
    !data_oe_n |-> output_gate_n && program_supply_en)
    else $error("Data driven while gate low or supply off");
  AST_PULSE_HELD: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(device_select_n) && program_supply_en && !data_oe_n |-> !device_select_n[*8])
    else $error("Program pulse too short");
  AST_PULSE_DATA: assert property (@(posedge clk_sys) disable iff (rst)
    !device_select_n && !data_oe_n |=> !data_oe_n && $stable(data_out))
    else $error("Data changed during program pulse");
  AST_VERIFY_FOLLOWS: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(device_select_n) && !data_oe_n |-> ##[400:1000] !output_gate_n)
    else $error("No verify read after program pulse");
  AST_SHARED_READ: assert property (@(posedge clk_sys) disable iff (rst)
    !output_gate_n && core_supply_high_en && !device_select_n |-> !program_supply_en)
    else $error("Shared verify with supply at programming level");
  AST_ID_ENABLES: assert property (@(posedge clk_sys) disable iff (rst)
    id_high_voltage_en && !output_gate_n |-> !device_select_n)
    else $error("Identifier read without both enables low");
  AST_ID_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
    id_high_voltage_en |-> dev_addr[eprom_host_pkg::ADDR_W-1:1] == '0)
    else $error("Identifier readout with upper address set");
  AST_NO_CONTENTION: assert property (@(posedge clk_sys) disable iff (rst)
    !output_gate_n |-> data_oe_n && (device_select_n == (op == eprom_host_pkg::OP_PROGRAM)))
    else $error("Gate low while host drives or select wrong");
  // Ready stands with the response; a waiting command may be taken in the same cycle
  AST_RSP_PULSE: assert property (@(posedge clk_sys) disable iff (rst)
    rsp_valid |-> cmd_ready ##1 !rsp_valid)
    else $error("Response not a single pulse");
endmodule
`default_nettype wire

// ==== verif/eprom_device_model.sv ====
// Purpose: Behavioural byte-wide programmable ROM on the far side of the pins.
// Assumes: Clockless; data lines resolved by the bench.
// Notes: DELAY_NS sets how fast data answers.
`timescale 1ns/1ps
`default_nettype none
module eprom_device_model #(
  parameter int DELAY_NS = 20,
  parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3c // Arbitrary value
) (
  input wire logic [14:0] addr,
  input wire logic device_select_n,
  input wire logic output_gate_n,
  input wire logic [7:0] bus,
  input wire logic program_supply,
  input wire logic core_supply_high,
  input wire logic id_high_voltage,
  output logic [7:0] dev_q,
  output logic dev_en
);
  logic [7:0] mem [0:32767];
  // Erased array holds all ones
  initial
  begin
    for (int i = 0; i < 32768; i++)
      mem[i] = 8'hff;
  end
  // Select pulse at supply clears bits only; select high inhibits
  always @(posedge device_select_n)
  begin
    if (program_supply && core_supply_high && output_gate_n)
      mem[addr] = mem[addr] & bus;
  end
  // Outputs gated by both enables, or by gate alone at supply
  assign #(DELAY_NS) dev_en = !output_gate_n && (!device_select_n || program_supply);
  // Identifier bytes when the id line is raised
  assign #(DELAY_NS) dev_q = (id_high_voltage && !device_select_n) ?
    (addr[0] ? DEV_CODE : MFR_CODE) : mem[addr];
endmodule
`default_nettype wire

// ==== verif/tb_eprom_host.sv ====
// Purpose: Self-checking bench for the programmer controller.
// Assumes: Short pulse and access parameters.
// Notes: Expected responses queue up at each command take.
`timescale 1ns/1ps
`default_nettype none
module tb_eprom_host;
  localparam logic [7:0] ID_MFR = 8'h5a; // Arbitrary value
  localparam logic [7:0] ID_DEV = 8'h3c; // Arbitrary value
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [14:0] cmd_addr = 15'h0000;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] float_pat = 8'h00;
  logic cmd_ready, rsp_valid, rsp_match, device_select_n, output_gate_n, data_oe_n;
  logic pse, cse, hve, dev_en;
  logic [14:0] dev_addr;
  logic [7:0] rsp_data, data_out, data_in, dev_q;
  logic [7:0] shadow [0:32767];
  logic [15:0] exp_q [$];
  int n_mismatch = 0;
  int checked = 0;

  always #5 clk_sys = ~clk_sys;

  eprom_host #(.PULSE_CYCLES(10), .ACCESS_NS(30)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_match(rsp_match),
    .dev_addr(dev_addr), .device_select_n(device_select_n), .output_gate_n(output_gate_n),
    .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in),
    .program_supply_en(pse), .core_supply_high_en(cse), .id_high_voltage_en(hve));

  eprom_device_model #(.DELAY_NS(20), .MFR_CODE(ID_MFR), .DEV_CODE(ID_DEV)) u_mem (
    .addr(dev_addr), .device_select_n(device_select_n), .output_gate_n(output_gate_n),
    .bus(data_in), .program_supply(pse), .core_supply_high(cse), .id_high_voltage(hve),
    .dev_q(dev_q), .dev_en(dev_en));

  // Resolved data lines; a released bus wanders every cycle
  assign data_in = !data_oe_n ? data_out : (dev_en ? dev_q : float_pat);
  always @(posedge clk_sys) float_pat <= float_pat + 8'h35;

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Issue one command and note its expected response
  task automatic send(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d);
    logic [7:0] got;
    logic prog;
    int i;
    prog = (op == 2'h1 || op == 2'h2);
    got = (op == 2'h3) ? (a[0] ? ID_DEV : ID_MFR) : (prog ? (shadow[a] & d) : shadow[a]);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (cmd_ready !== 1'b1 && i < 3000);
    if (i >= 3000)
    begin
      n_mismatch++;
      close_out();
    end
    cmd_valid <= 1'b0;
    if (prog)
      shadow[a] = got;
    exp_q.push_back({7'h00, prog ? (got == d) : 1'b1, got});
  endtask

  // Response and pin watcher
  always @(posedge clk_sys)
  begin
    if (rsp_valid === 1'b1)
      chk("rsp", {7'h00, rsp_match, rsp_data}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    chk("bus_clash", {15'h0000, data_oe_n === 1'b0 && dev_en === 1'b1}, 16'h0000);
    if (hve === 1'b1)
      chk("id_addr", {2'h0, dev_addr[14:1]}, 16'h0000);
    if (pse === 1'b1 && device_select_n === 1'b0 && output_gate_n === 1'b1)
      chk("prog_drive", {15'h0000, data_oe_n}, 16'h0000);
  end

  initial
  begin
    logic [31:0] r;
    for (int i = 0; i < 32768; i++)
      shadow[i] = 8'hff;
    void'($urandom(4));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("idle_pins", {10'h000, device_select_n, output_gate_n, data_oe_n, pse, cse, hve},
      16'h0038);
    send(2'h0, 15'h7fff, 8'h00);
    send(2'h3, 15'h7ffe, 8'h00);
    send(2'h3, 15'h0001, 8'hff);
    send(2'h1, 15'h0000, 8'ha5);
    send(2'h1, 15'h0000, 8'h5a);
    send(2'h2, 15'h7fff, 8'h0f);
    send(2'h0, 15'h0000, 8'h00);
    // Random mix over a few addresses so bytes are revisited
    for (int k = 0; k < 14; k++)
    begin
      r = $urandom;
      send(r[1:0], {12'h000, r[4:2]}, r[15:8]);
    end
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++)
      @(posedge clk_sys);
    if (exp_q.size() > 0)
      n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
